// file: verilog/paged_port_pkg.sv
package paged_port_pkg;

    // slave address: fixed upper nibble, then two straps, then space bit, then r/w
    localparam logic [3:0] SLAVE_FIXED_BITS = 4'ha;
    localparam int OFFSET_BITS = 7;
    localparam int PAGE_BITS = 3;
    localparam int NUM_PAGES = 8;
    localparam int NUM_SPACES = 2;
    localparam int MEM_WORDS = NUM_SPACES * NUM_PAGES * 128;
    localparam logic [6:0] PAGE_SELECT_OFFSET = 7'h7f;
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam logic [6:0] PRIO_LOW_OFFSET = 7'h00;
    localparam logic [6:0] PRIO_HIGH_OFFSET = 7'h01;
    localparam logic [2:0] PRIO_PAGE = 3'h2;
    // address bit 1 set reaches the digital loops and first two analog loops
    localparam logic LOOP_SPACE = 1'b1;
    localparam logic THIRD_ANALOG_SPACE = 1'b0;
    localparam logic [15:0] PRIO_TABLE_RESET = 16'h0000;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] OFFSET_RESET = 7'h00;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_OFFS      = 9'h008,
        ST_OFFS_ACK  = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_RDATA_ACK = 9'h100
    } port_state_e;

endpackage

// file: verilog/reg_access_if.sv
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
    logic wr_en;
    logic space;
    logic [6:0] offset;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [15:0] prio_table;

    modport port
    (
        output wr_en,
        output space,
        output offset,
        output wdata,
        input rdata,
        input prio_table
    );

    modport store
    (
        input wr_en,
        input space,
        input offset,
        input wdata,
        output rdata,
        output prio_table
    );
endinterface
`default_nettype wire

// file: verilog/paged_reg_store.sv
`timescale 1ns/1ps
`default_nettype none
module paged_reg_store
    import paged_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    reg_access_if.store acc
);
    logic [7:0] mem [0:MEM_WORDS-1];
    logic [7:0] page_sel [0:NUM_SPACES-1];
    logic [7:0] next_page_sel [0:NUM_SPACES-1];
    logic [7:0] prio_low_stage;
    logic [7:0] next_prio_low_stage;
    logic [15:0] prio_table;
    logic [15:0] next_prio_table;
    logic [PAGE_BITS-1:0] cur_page;
    logic [10:0] index;

    // offset decodes only inside the page active for that space
    assign cur_page = page_sel[acc.space][PAGE_BITS-1:0];
    assign index = {acc.space, cur_page, acc.offset};
    assign acc.rdata = (acc.offset == PAGE_SELECT_OFFSET) ? page_sel[acc.space]
                                                          : mem[index];
    assign acc.prio_table = prio_table;

    always_comb
    begin
        next_page_sel = page_sel;
        next_prio_low_stage = prio_low_stage;
        next_prio_table = prio_table;
        if (acc.wr_en)
        begin
            if (acc.offset == PAGE_SELECT_OFFSET)
            begin
                next_page_sel[acc.space] = acc.wdata;
            end
            else if (acc.space == LOOP_SPACE && cur_page == PRIO_PAGE)
            begin
                // the table only changes when its last byte lands
                if (acc.offset == PRIO_LOW_OFFSET)
                begin
                    next_prio_low_stage = acc.wdata;
                end
                else if (acc.offset == PRIO_HIGH_OFFSET)
                begin
                    next_prio_table = {acc.wdata, prio_low_stage};
                end
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            page_sel[0] <= PAGE_SELECT_RESET;
            page_sel[1] <= PAGE_SELECT_RESET;
            prio_low_stage <= PRIO_TABLE_RESET[7:0];
            prio_table <= PRIO_TABLE_RESET;
        end
        else
        begin
            page_sel <= next_page_sel;
            prio_low_stage <= next_prio_low_stage;
            prio_table <= next_prio_table;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (acc.wr_en && acc.offset != PAGE_SELECT_OFFSET)
        begin
            mem[index] <= acc.wdata;
        end
    end
endmodule
`default_nettype wire

// file: verilog/i2c_paged_register_port.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_paged_register_port
    import paged_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic addr_strap_hi_in,
    input wire logic addr_strap_lo_in,
    input wire logic boot_done_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [15:0] prio_table_out
);
    reg_access_if acc ();

    paged_reg_store store_i
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .acc(acc.store)
    );

    // pin synchronisers; stage 1 feeds stage 2 only
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic scl_q;
    logic sda_q;
    logic scl_s;
    logic sda_s;
    logic [1:0] strap_s;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sync1 <= 4'hf;
            sync2 <= 4'hf;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            sync1 <= {addr_strap_hi_in, addr_strap_lo_in, scl_in, sda_in};
            sync2 <= sync1;
            scl_q <= sync2[1];
            sda_q <= sync2[0];
        end
    end

    assign scl_s = sync2[1];
    assign sda_s = sync2[0];
    assign strap_s = sync2[3:2];

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;

    port_state_e state;
    port_state_e next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic space;
    logic next_space;
    logic [6:0] ptr;
    logic [6:0] next_ptr;
    logic oe;
    logic next_oe;
    logic wr_en;
    logic next_wr_en;
    logic [7:0] wdata;
    logic [7:0] next_wdata;
    logic [6:0] wr_offset;
    logic [6:0] next_wr_offset;
    logic nacked;
    logic next_nacked;
    logic addr_match;

    // the write path uses the latched offset, reads always follow the pointer
    assign acc.wr_en = wr_en;
    assign acc.space = space;
    assign acc.offset = wr_en ? wr_offset : ptr;
    assign acc.wdata = wdata;

    always_comb
    begin
        addr_match = (shreg[7:4] == SLAVE_FIXED_BITS)
                     && (shreg[3:2] == strap_s)
                     && boot_done_in;
    end

    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_space = space;
        next_ptr = ptr;
        next_oe = oe;
        next_wr_en = 1'b0;
        next_wdata = wdata;
        next_wr_offset = wr_offset;
        next_nacked = nacked;
        if (start_ev)
        begin
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_oe = 1'b0;
        end
        else if (stop_ev)
        begin
            next_state = ST_IDLE;
            next_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            case (state)
                ST_ADDR, ST_OFFS, ST_WDATA:
                begin
                    next_shreg = {shreg[6:0], sda_s};
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                ST_RDATA:
                begin
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                ST_RDATA_ACK:
                begin
                    next_nacked = sda_s;
                end
                default:
                begin
                    next_bit_cnt = bit_cnt;
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (state)
                ST_ADDR:
                begin
                    if (bit_cnt == BITS_PER_BYTE)
                    begin
                        if (addr_match)
                        begin
                            next_space = shreg[1];
                            next_oe = 1'b1;
                            next_state = ST_ADDR_ACK;
                        end
                        else
                        begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    next_bit_cnt = 4'h0;
                    if (shreg[0])
                    begin
                        // read begins at the pointer left by the last access
                        next_shreg = acc.rdata;
                        next_oe = ~acc.rdata[7];
                        next_state = ST_RDATA;
                    end
                    else
                    begin
                        next_oe = 1'b0;
                        next_state = ST_OFFS;
                    end
                end
                ST_OFFS:
                begin
                    if (bit_cnt == BITS_PER_BYTE)
                    begin
                        next_ptr = shreg[6:0];
                        next_oe = 1'b1;
                        next_state = ST_OFFS_ACK;
                    end
                end
                ST_OFFS_ACK, ST_WDATA_ACK:
                begin
                    next_oe = 1'b0;
                    next_bit_cnt = 4'h0;
                    next_state = ST_WDATA;
                end
                ST_WDATA:
                begin
                    if (bit_cnt == BITS_PER_BYTE)
                    begin
                        next_wr_en = 1'b1;
                        next_wdata = shreg;
                        next_wr_offset = ptr;
                        next_ptr = ptr + 7'h01;
                        next_oe = 1'b1;
                        next_state = ST_WDATA_ACK;
                    end
                end
                ST_RDATA:
                begin
                    if (bit_cnt == BITS_PER_BYTE)
                    begin
                        next_oe = 1'b0;
                        next_ptr = ptr + 7'h01;
                        next_state = ST_RDATA_ACK;
                    end
                    else
                    begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_oe = ~shreg[6];
                    end
                end
                ST_RDATA_ACK:
                begin
                    next_bit_cnt = 4'h0;
                    if (nacked)
                    begin
                        next_state = ST_IDLE;
                    end
                    else
                    begin
                        next_shreg = acc.rdata;
                        next_oe = ~acc.rdata[7];
                        next_state = ST_RDATA;
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            space <= THIRD_ANALOG_SPACE;
            ptr <= OFFSET_RESET;
            oe <= 1'b0;
            wr_en <= 1'b0;
            wdata <= 8'h00;
            wr_offset <= OFFSET_RESET;
            nacked <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            space <= next_space;
            ptr <= next_ptr;
            oe <= next_oe;
            wr_en <= next_wr_en;
            wdata <= next_wdata;
            wr_offset <= next_wr_offset;
            nacked <= next_nacked;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
            prio_table_out <= PRIO_TABLE_RESET;
        end
        else
        begin
            sda_out <= 1'b0;
            sda_oe_out <= next_oe;
            prio_table_out <= acc.prio_table;
        end
    end
endmodule
`default_nettype wire

// file: testbench/i2c_port_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_port_checker
    import paged_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic boot_done_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [15:0] prio_table_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [7:0] oe_run;
    logic [7:0] next_oe_run;
    always_comb next_oe_run = sda_oe_out ? oe_run + 8'h01 : 8'h00;
    always_ff @(posedge clk_in) oe_run <= rst_in ? 8'h00 : next_oe_run;
    property p_pull_only; sda_oe_out |-> !sda_out; endproperty
    property p_no_boot; !boot_done_in |-> !sda_oe_out; endproperty
    property p_commit_acked; $changed(prio_table_out) |-> sda_oe_out; endproperty
    property p_commit_once; $changed(prio_table_out) |=> $stable(prio_table_out)[*8]; endproperty
    property p_oe_scl_low; $changed(sda_oe_out) |-> !scl_in ##1 !scl_in ##1 !scl_in; endproperty
    property p_oe_bounded; oe_run < 8'd200; endproperty
    property p_stop_quiet; scl_in && $past(scl_in) && $rose(sda_in) |-> !sda_oe_out; endproperty
    property p_reset_clean;
        $fell(rst_in) |-> !sda_oe_out && prio_table_out == PRIO_TABLE_RESET;
    endproperty
    a_pull_only: assert property (p_pull_only) else $error("sda driven high");
    a_no_boot: assert property (p_no_boot) else $error("answer before boot load");
    a_commit_acked: assert property (p_commit_acked) else $error("table moved off a byte");
    a_commit_once: assert property (p_commit_once) else $error("table changed twice");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved near scl high");
    a_oe_bounded: assert property (p_oe_bounded) else $error("sda held low too long");
    a_stop_quiet: assert property (p_stop_quiet) else $error("driving after stop");
    a_reset_clean: assert property (p_reset_clean) else $error("unclean after reset");
    c_commit: cover property ($changed(prio_table_out));
    c_ack: cover property ($rose(sda_oe_out));
    c_stop: cover property (scl_in && $rose(sda_in));
endmodule
bind i2c_paged_register_port i2c_port_checker checker_inst (.clk_in(clk_in), .rst_in(rst_in),
    .scl_in(scl_in), .sda_in(sda_in), .boot_done_in(boot_done_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .prio_table_out(prio_table_out));
`default_nettype wire

// file: testbench/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // quarter of a 160 ns bit; scl stands high between frames
    task automatic q();
        repeat (4) @(negedge clk_in);
    endtask
    task automatic start();
        sda_low_out = 1'b0;
        q();
        scl_out = 1'b1;
        q();
        sda_low_out = 1'b1;
        q();
        scl_out = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        q();
        scl_out = 1'b1;
        q();
        sda_low_out = 1'b0;
        q();
    endtask
    task automatic bit_cycle(input logic b, output logic s);
        sda_low_out = !b;
        q();
        scl_out = 1'b1;
        q();
        s = sda_in;
        q();
        scl_out = 1'b0;
        q();
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], s);
        bit_cycle(1'b1, ack);
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b1, b[i]);
        bit_cycle(last, s);
    endtask
endmodule
`default_nettype wire

// file: testbench/test_i2c_paged_register_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_i2c_paged_register_port
    import paged_port_pkg::*;
;
    logic clk_in;
    logic rst_in;
    logic boot_done;
    logic strap_hi;
    logic strap_lo;
    logic scl;
    logic m_low;
    logic sda_o;
    logic sda_oe;
    logic [15:0] prio;
    logic ack;
    logic [7:0] rb;
    int failures = 0;
    int cmp_count = 0;
    wire logic sda_bus = !(m_low || (sda_oe && !sda_o));
    i2c_paged_register_port i2c_paged_register_port_inst (.clk_in(clk_in), .rst_in(rst_in),
        .scl_in(scl), .sda_in(sda_bus), .addr_strap_hi_in(strap_hi),
        .addr_strap_lo_in(strap_lo), .boot_done_in(boot_done), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .prio_table_out(prio));
    i2c_master_model i2c_master_model_inst (.clk_in(clk_in), .sda_in(sda_bus),
        .scl_out(scl), .sda_low_out(m_low));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [7:0] dev(input logic sp, input logic rd);
        return {SLAVE_FIXED_BITS, 2'b10, sp, rd};
    endfunction
    task automatic probe(input logic [7:0] a);
        i2c_master_model_inst.start();
        i2c_master_model_inst.send_byte(a, ack);
        i2c_master_model_inst.stop();
        check(16'(ack), 16'h0001);
    endtask
    task automatic wr(input logic sp, input logic [7:0] off, input logic [7:0] d[$]);
        i2c_master_model_inst.start();
        i2c_master_model_inst.send_byte(dev(sp, 1'b0), ack);
        check(16'(ack), 16'h0000);
        i2c_master_model_inst.send_byte(off, ack);
        check(16'(ack), 16'h0000);
        foreach (d[i])
        begin
            i2c_master_model_inst.send_byte(d[i], ack);
            check(16'(ack), 16'h0000);
        end
        i2c_master_model_inst.stop();
    endtask
    task automatic rd(input logic sp, input logic use_off, input logic [7:0] off,
        input logic [7:0] e[$]);
        if (use_off)
        begin
            i2c_master_model_inst.start();
            i2c_master_model_inst.send_byte(dev(sp, 1'b0), ack);
            check(16'(ack), 16'h0000);
            i2c_master_model_inst.send_byte(off, ack);
            check(16'(ack), 16'h0000);
        end
        i2c_master_model_inst.start();
        i2c_master_model_inst.send_byte(dev(sp, 1'b1), ack);
        check(16'(ack), 16'h0000);
        foreach (e[i])
        begin
            i2c_master_model_inst.recv_byte(i == e.size() - 1, rb);
            check(16'(rb), 16'(e[i]));
        end
        i2c_master_model_inst.stop();
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (40000) @(posedge clk_in);
        failures++;
        give_verdict();
    end
    initial
    begin
        rst_in = 1'b1;
        boot_done = 1'b0;
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check(prio, PRIO_TABLE_RESET);
        probe(dev(1'b1, 1'b0));
        boot_done = 1'b1;
        probe({4'hb, 2'b10, 2'b10});
        probe({SLAVE_FIXED_BITS, 2'b01, 2'b10});
        wr(1'b1, 8'h7f, '{8'h02});
        wr(1'b1, 8'h00, '{8'h5a});
        check(prio, PRIO_TABLE_RESET);
        wr(1'b1, 8'h01, '{8'hc3});
        repeat (4) @(negedge clk_in);
        check(prio, 16'hc35a);
        wr(1'b1, 8'h7e, '{8'h33, 8'h02, 8'h44});
        check(prio, 16'hc35a);
        rd(1'b1, 1'b0, 8'h00, '{8'hc3});
        rd(1'b1, 1'b1, 8'h7e, '{8'h33, 8'h02, 8'h44, 8'hc3});
        wr(1'b1, 8'h7f, '{8'h03});
        wr(1'b1, 8'h00, '{8'h77});
        rd(1'b1, 1'b1, 8'h7f, '{8'h03, 8'h77});
        wr(1'b1, 8'h7f, '{8'h02});
        rd(1'b1, 1'b1, 8'h00, '{8'h44});
        wr(1'b0, 8'h00, '{8'h99});
        rd(1'b0, 1'b1, 8'h7f, '{8'h00, 8'h99});
        rd(1'b1, 1'b1, 8'h00, '{8'h44});
        // offset bit 7 lies outside the page and is ignored
        rd(1'b1, 1'b1, 8'h80, '{8'h44});
        // move the straps: the old address must go deaf, the new one answer
        strap_hi = 1'b0;
        strap_lo = 1'b1;
        repeat (4) @(negedge clk_in);
        probe(dev(1'b1, 1'b0));
        i2c_master_model_inst.start();
        i2c_master_model_inst.send_byte({SLAVE_FIXED_BITS, 2'b01, 2'b10}, ack);
        i2c_master_model_inst.stop();
        check(16'(ack), 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
